// File: logic/sdp_top.sv
// stereo dac serial port: sample buffer, channel fifos, serial link, control port
`timescale 1ns/1ps
`include "sdp_defines.svh"
module sdp_top (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic link_clk_i,
    input wire logic [`SDP_SAMPLE_W-1:0] left_sample_i,
    input wire logic [`SDP_SAMPLE_W-1:0] right_sample_i,
    input wire logic sample_valid_i,
    output logic sample_ready_o,
    output logic refill_irq_o,
    input wire logic ctrl_scl_i,
    input wire logic ctrl_sda_i,
    output logic ctrl_sda_o,
    output logic dac_mclk_o,
    output logic channel_select_clock_o,
    output logic audio_serial_out_o,
    output logic dac_scl_o,
    input wire logic dac_sda_i,
    output logic dac_sda_o,
    output logic dac_sda_oe_o
);
    sdp_fifo_if left_if ();
    sdp_fifo_if right_if ();
    logic lnk_rst_meta_reg, lnk_rst_reg;

    // -------------------------------------------------
    // two-entry sample buffer (system clock)
    // -------------------------------------------------
    logic [`SDP_FRAME_W-1:0] buf0_reg, buf1_reg;
    logic [1:0] cnt_reg;
    logic ready_reg;
    wire push = sample_valid_i && ready_reg;
    wire pop = (cnt_reg != 2'h0) && !left_if.full && !right_if.full;
    wire [1:0] slot = cnt_reg - {1'b0, pop};
    wire [1:0] cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
    wire [`SDP_FRAME_W-1:0] in_word = {left_sample_i, right_sample_i};

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            cnt_reg <= '0;
            ready_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            ready_reg <= (cnt_next != `SDP_SKID_FULL);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (pop) begin
            buf0_reg <= buf1_reg;
        end
        if (push && slot == 2'h0) begin
            buf0_reg <= in_word;
        end
        if (push && slot == 2'h1) begin
            buf1_reg <= in_word;
        end
    end

    // both channels written together so pairs stay aligned
    assign left_if.wr_en = pop;
    assign right_if.wr_en = pop;
    assign left_if.wdata = buf0_reg[`SDP_FRAME_W-1:`SDP_SAMPLE_W];
    assign right_if.wdata = buf0_reg[`SDP_SAMPLE_W-1:0];
    assign sample_ready_o = ready_reg;

    chk_buffer_ready_full: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (cnt_reg == `SDP_SKID_FULL) |-> !sample_ready_o)
        else $error("buffer full but ready shown");

    // -------------------------------------------------
    // channel fifos
    // -------------------------------------------------
    sdp_async_fifo left_fifo (
        .wr_clk_i(sys_clk_i),
        .wr_rst_i(sys_rst_i),
        .rd_clk_i(link_clk_i),
        .rd_rst_i(lnk_rst_reg),
        .port_if(left_if)
    );

    sdp_async_fifo right_fifo (
        .wr_clk_i(sys_clk_i),
        .wr_rst_i(sys_rst_i),
        .rd_clk_i(link_clk_i),
        .rd_rst_i(lnk_rst_reg),
        .port_if(right_if)
    );

    // -------------------------------------------------
    // serial link (link clock)
    // -------------------------------------------------
    sdp_pkg::sdp_state_t state_reg, state_next;
    logic [1:0] div_reg;
    logic [4:0] bit_reg;
    logic got_reg, mclk_reg, lr_reg, sdo_reg, pop_tgl_reg;
    logic [`SDP_FRAME_W-1:0] sh_reg;

    always_ff @(posedge link_clk_i) begin
        lnk_rst_meta_reg <= sys_rst_i;
        lnk_rst_reg <= lnk_rst_meta_reg;
    end

    wire div_wrap = (div_reg == `SDP_DIV_LAST);
    wire at_last = (bit_reg == `SDP_BIT_LAST);
    wire at_fetch = at_last && (div_reg == `SDP_DIV_FETCH);
    wire fetch = at_fetch && !left_if.empty && !right_if.empty;
    wire frame_load = div_wrap && at_last;
    wire [4:0] bit_next = bit_reg + 5'h01;
    wire [`SDP_FRAME_W-1:0] load_word = got_reg ? {left_if.rdata, right_if.rdata} : '0;
    wire [`SDP_FRAME_W-1:0] sh_next = !div_wrap ? sh_reg :
        (at_last ? load_word : {sh_reg[`SDP_FRAME_W-2:0], 1'b0});
    assign left_if.rd_en = fetch;
    assign right_if.rd_en = fetch;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            sdp_pkg::SDP_IDLE: begin
                if (frame_load && got_reg) begin
                    state_next = sdp_pkg::SDP_RUN;
                end
            end
            sdp_pkg::SDP_RUN: begin
                if (frame_load && !got_reg) begin
                    state_next = sdp_pkg::SDP_IDLE;
                end
            end
            default: begin
                state_next = sdp_pkg::SDP_IDLE;
            end
        endcase
    end

    always_ff @(posedge link_clk_i) begin
        if (lnk_rst_reg) begin
            state_reg <= sdp_pkg::SDP_IDLE;
            div_reg <= '0;
            bit_reg <= `SDP_BIT_LAST;
            got_reg <= 1'b0;
            mclk_reg <= 1'b0;
            lr_reg <= 1'b0;
            sdo_reg <= 1'b0;
            sh_reg <= '0;
            pop_tgl_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            div_reg <= div_reg + 2'h1;
            mclk_reg <= ~mclk_reg;
            sh_reg <= sh_next;
            sdo_reg <= sh_next[`SDP_FRAME_W-1];
            if (fetch) begin
                got_reg <= 1'b1;
            end else if (frame_load) begin
                got_reg <= 1'b0;
            end
            if (div_wrap) begin
                bit_reg <= bit_next;
                lr_reg <= ~bit_next[`SDP_HALF_BIT];
            end
            if (fetch && left_if.last) begin
                pop_tgl_reg <= ~pop_tgl_reg;
            end
        end
    end

    assign dac_mclk_o = mclk_reg;
    assign channel_select_clock_o = lr_reg;
    assign audio_serial_out_o = sdo_reg;

    chk_lr_half_frame: assert property (@(posedge link_clk_i) disable iff (lnk_rst_reg)
        $rose(lr_reg) |-> ##63 lr_reg ##1 !lr_reg)
        else $error("channel clock half frame not 64 cycles");

    chk_mclk_divide: assert property (@(posedge link_clk_i) disable iff (lnk_rst_reg)
        !lnk_rst_reg |=> (mclk_reg != $past(mclk_reg)))
        else $error("master clock not toggling");

    chk_fetch_to_run: assert property (@(posedge link_clk_i) disable iff (lnk_rst_reg)
        fetch |-> ##4 (lr_reg && state_reg == sdp_pkg::SDP_RUN))
        else $error("fetched pair not loaded at left slot");

    // -------------------------------------------------
    // refill interrupt (system clock)
    // -------------------------------------------------
    logic tgl_meta_reg, tgl_sync_reg, tgl_prev_reg, irq_reg;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            tgl_meta_reg <= 1'b0;
            tgl_sync_reg <= 1'b0;
            tgl_prev_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            tgl_meta_reg <= pop_tgl_reg;
            tgl_sync_reg <= tgl_meta_reg;
            tgl_prev_reg <= tgl_sync_reg;
            irq_reg <= tgl_sync_reg ^ tgl_prev_reg;
        end
    end

    assign refill_irq_o = irq_reg;

    chk_irq_one_pulse: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        refill_irq_o |=> !refill_irq_o)
        else $error("refill interrupt longer than one cycle");

    // -------------------------------------------------
    // software-driven control port
    // -------------------------------------------------
    logic scl_reg, sda_oe_reg, sda_out_reg, sda_meta_reg, sda_sync_reg;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            scl_reg <= 1'b1;
            sda_oe_reg <= 1'b0;
            sda_out_reg <= 1'b0;
            sda_meta_reg <= 1'b1;
            sda_sync_reg <= 1'b1;
        end else begin
            scl_reg <= ctrl_scl_i;
            sda_oe_reg <= ~ctrl_sda_i;
            sda_out_reg <= 1'b0;
            sda_meta_reg <= dac_sda_i;
            sda_sync_reg <= sda_meta_reg;
        end
    end

    assign dac_scl_o = scl_reg;
    assign dac_sda_oe_o = sda_oe_reg;
    assign dac_sda_o = sda_out_reg;
    assign ctrl_sda_o = sda_sync_reg;

    chk_sda_open_drain: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        !sys_rst_i |=> (dac_sda_oe_o == !$past(ctrl_sda_i)) && !dac_sda_o)
        else $error("data pin drive does not follow software");
endmodule // sdp_top

// File: logic/sdp_defines.svh
// constants of the stereo dac serial port
//
// Summary of operation
// - two four-word fifos, one per channel
// - bit and divider counters move words, keep stream gapless
// - pulse interrupt when fifos hand last word
// - channel clock level marks channel being shifted
// - control port is software-driven two-bit port
`ifndef SDP_DEFINES_SVH
`define SDP_DEFINES_SVH

`define SDP_SAMPLE_W 16
`define SDP_FRAME_W 32
`define SDP_PTR_W 3
`define SDP_FIFO_DEPTH 4
`define SDP_DIV_FETCH 2'h0
`define SDP_DIV_LAST 2'h3
`define SDP_BIT_LAST 5'h1F
`define SDP_HALF_BIT 4
`define SDP_SKID_FULL 2'h2
`define SDP_PTR_ONE 3'h1

`endif

// File: logic/sdp_pkg.sv
// types of the stereo dac serial port
package sdp_pkg;
    typedef enum logic {
        SDP_IDLE,
        SDP_RUN
    } sdp_state_t;
endpackage

// File: logic/sdp_fifo_if.sv
// carrier between the top and one channel fifo
`timescale 1ns/1ps
`include "sdp_defines.svh"
interface sdp_fifo_if;
    logic [`SDP_SAMPLE_W-1:0] wdata;
    logic wr_en;
    logic full;
    logic [`SDP_SAMPLE_W-1:0] rdata;
    logic rd_en;
    logic empty;
    logic last;
    modport user (output wdata, output wr_en, input full,
                  input rdata, output rd_en, input empty, input last);
    modport fifo (input wdata, input wr_en, output full,
                  output rdata, input rd_en, output empty, output last);
endinterface

// File: logic/sdp_async_fifo.sv
// four-word dual-clock channel fifo with registered read data
`timescale 1ns/1ps
`include "sdp_defines.svh"
module sdp_async_fifo (
    input wire logic wr_clk_i,
    input wire logic wr_rst_i,
    input wire logic rd_clk_i,
    input wire logic rd_rst_i,
    sdp_fifo_if.fifo port_if
);
    logic [`SDP_SAMPLE_W-1:0] mem_reg [0:`SDP_FIFO_DEPTH-1];
    logic [`SDP_PTR_W-1:0] wbin_reg, wgray_reg, rbin_reg, rgray_reg;
    logic [`SDP_PTR_W-1:0] rq1_reg, rq2_reg, wq1_reg, wq2_reg;
    logic [`SDP_SAMPLE_W-1:0] rdata_reg;

    function automatic logic [`SDP_PTR_W-1:0] g2b(input logic [`SDP_PTR_W-1:0] g);
        logic [`SDP_PTR_W-1:0] b;
        b = g;
        for (int i = `SDP_PTR_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // -------------------------------------------------
    // write side
    // -------------------------------------------------
    wire [`SDP_PTR_W-1:0] wbin_next = wbin_reg + `SDP_PTR_ONE;
    wire do_write = port_if.wr_en && !port_if.full;
    assign port_if.full = (wgray_reg == {~rq2_reg[`SDP_PTR_W-1:`SDP_PTR_W-2],
                                         rq2_reg[`SDP_PTR_W-3:0]});

    always_ff @(posedge wr_clk_i) begin
        if (wr_rst_i) begin
            wbin_reg <= '0;
            wgray_reg <= '0;
            rq1_reg <= '0;
            rq2_reg <= '0;
        end else begin
            rq1_reg <= rgray_reg;
            rq2_reg <= rq1_reg;
            if (do_write) begin
                wbin_reg <= wbin_next;
                wgray_reg <= wbin_next ^ (wbin_next >> 1);
            end
        end
    end

    always_ff @(posedge wr_clk_i) begin
        if (do_write) begin
            mem_reg[wbin_reg[`SDP_PTR_W-2:0]] <= port_if.wdata;
        end
    end

    chk_fifo_no_overflow: assert property (@(posedge wr_clk_i) disable iff (wr_rst_i)
        port_if.wr_en |-> !port_if.full)
        else $error("fifo written while full");

    // -------------------------------------------------
    // read side
    // -------------------------------------------------
    wire [`SDP_PTR_W-1:0] rbin_next = rbin_reg + `SDP_PTR_ONE;
    wire do_read = port_if.rd_en && !port_if.empty;
    wire [`SDP_PTR_W-1:0] wbin_sync = g2b(wq2_reg);
    assign port_if.empty = (rgray_reg == wq2_reg);
    assign port_if.last = ((wbin_sync - rbin_reg) == `SDP_PTR_ONE);
    assign port_if.rdata = rdata_reg;

    always_ff @(posedge rd_clk_i) begin
        if (rd_rst_i) begin
            rbin_reg <= '0;
            rgray_reg <= '0;
            wq1_reg <= '0;
            wq2_reg <= '0;
            rdata_reg <= '0;
        end else begin
            wq1_reg <= wgray_reg;
            wq2_reg <= wq1_reg;
            if (do_read) begin
                rdata_reg <= mem_reg[rbin_reg[`SDP_PTR_W-2:0]];
                rbin_reg <= rbin_next;
                rgray_reg <= rbin_next ^ (rbin_next >> 1);
            end
        end
    end

    chk_fifo_no_underflow: assert property (@(posedge rd_clk_i) disable iff (rd_rst_i)
        port_if.rd_en |-> !port_if.empty)
        else $error("fifo read while empty");
endmodule // sdp_async_fifo

// File: verification/sdp_dac_model.sv
// behavioural model of the external stereo dac
`timescale 1ns/1ps
module sdp_dac_model (
    input wire logic link_clk_i,
    input wire logic chan_clk_i,
    input wire logic ser_i,
    input wire logic sda_oe_i,
    input wire logic pull_i,
    output logic sda_pin_o,
    output logic [15:0] left_o,
    output logic [15:0] right_o,
    output logic pair_stb_o
);
    logic prev_reg = 1'b0;
    logic [5:0] cnt_reg = 6'h00;
    logic [15:0] sh_reg = 16'h0000;
    // pulled-up data line, low if either side pulls
    assign sda_pin_o = !(sda_oe_i || pull_i);
    // sample each bit mid slot, channel taken from the channel clock level
    always @(posedge link_clk_i) begin
        logic [5:0] c;
        logic [15:0] w;
        c = (chan_clk_i != prev_reg) ? 6'h00 : cnt_reg + 6'h01;
        w = {sh_reg[14:0], ser_i};
        prev_reg <= chan_clk_i;
        cnt_reg <= c;
        pair_stb_o <= 1'b0;
        if (c[1:0] == 2'h1) sh_reg <= w;
        if (c == 6'h3D && chan_clk_i) left_o <= w;
        if (c == 6'h3D && !chan_clk_i) begin
            right_o <= w;
            pair_stb_o <= |{left_o, w};
        end
    end
endmodule // sdp_dac_model

// File: verification/sdp_top_tb_top.sv
// self-checking testbench of the stereo dac serial port
`timescale 1ns/1ps
module sdp_top_tb_top;
    typedef struct {logic [15:0] l; logic [15:0] r; logic scl; logic sda; logic pull;} sdp_row_t;
    logic sys_clk_i = 0, sys_rst_i = 1, link_clk = 0, valid = 0, scl = 1, sda = 1, pull = 0;
    logic [15:0] l = 16'h0000, r = 16'h0000;
    logic ready, irq, irq_d, sda_rd, mclk, chan_clk, sdo, dscl, sda_o, oe, pin, stb, m_prev;
    logic [15:0] ml, mr;
    logic [31:0] exp_q[$];
    int n_errors = 0, samples_checked = 0, n_irq = 0, acc, k, hi, tg;
    sdp_row_t rows[4] = '{'{16'h8001, 16'h7FFE, 1'b0, 1'b1, 1'b0},
        '{16'hFFFF, 16'h0001, 1'b1, 1'b0, 1'b0}, '{16'hA5C3, 16'h5A3C, 1'b1, 1'b1, 1'b1},
        '{16'h0100, 16'h8000, 1'b0, 1'b0, 1'b1}};
    initial forever #2.5 sys_clk_i = ~sys_clk_i;
    initial begin
        #7;
        forever #15 link_clk = ~link_clk;
    end
    sdp_top uut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .link_clk_i(link_clk),
        .left_sample_i(l), .right_sample_i(r), .sample_valid_i(valid),
        .sample_ready_o(ready), .refill_irq_o(irq), .ctrl_scl_i(scl), .ctrl_sda_i(sda),
        .ctrl_sda_o(sda_rd), .dac_mclk_o(mclk), .channel_select_clock_o(chan_clk),
        .audio_serial_out_o(sdo), .dac_scl_o(dscl), .dac_sda_i(pin), .dac_sda_o(sda_o),
        .dac_sda_oe_o(oe));
    sdp_dac_model dac (.link_clk_i(link_clk), .chan_clk_i(chan_clk), .ser_i(sdo), .sda_oe_i(oe),
        .pull_i(pull), .sda_pin_o(pin), .left_o(ml), .right_o(mr), .pair_stb_o(stb));
    task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task conclude;
        $display("errors %0d of %0d checks", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task push(input logic [15:0] a, input logic [15:0] b);
        int t;
        t = 0;
        @(negedge sys_clk_i);
        l = a;
        r = b;
        valid = 1;
        while (ready !== 1'b1 && t < 5000) begin
            @(negedge sys_clk_i);
            t++;
        end
        if (t >= 5000) check(0, 1, "ready stuck");
        else exp_q.push_back({a, b});
        @(posedge sys_clk_i);
    endtask
    always @(posedge sys_clk_i) begin
        if (irq === 1'b1) begin
            n_irq++;
            check(irq_d, 0, "irq pulse too long");
        end
        irq_d <= irq;
    end
    always @(posedge link_clk) begin
        if (stb === 1'b1) begin
            if (exp_q.size() == 0) check(0, 1, "unexpected pair");
            else check({ml, mr}, exp_q.pop_front(), "pair");
        end
    end
    initial begin
        #200000;
        n_errors++;
        conclude;
    end
    initial begin
        repeat (5) @(posedge link_clk);
        @(negedge sys_clk_i);
        check({ready, irq, dscl, oe, sda_o, mclk, chan_clk, sdo}, 8'h20, "reset values");
        sys_rst_i = 0;
        foreach (rows[i]) begin
            @(negedge sys_clk_i);
            scl = rows[i].scl;
            sda = rows[i].sda;
            pull = rows[i].pull;
            push(rows[i].l, rows[i].r);
            @(negedge sys_clk_i) valid = 0;
            repeat (3) @(negedge sys_clk_i);
            check({dscl, oe, sda_o, sda_rd},
                {rows[i].scl, !rows[i].sda, 1'b0, rows[i].sda & !rows[i].pull}, "port");
        end
        repeat (700) @(posedge link_clk);
        check(exp_q.size(), 0, "pairs left");
        @(posedge chan_clk);
        k = n_irq;
        for (int i = 0; i < 8; i++) begin
            if (i == 6) begin
                @(negedge sys_clk_i) valid = 0;
                acc = 0;
                repeat (20) @(negedge sys_clk_i) acc += (ready === 1'b1);
                check(acc, 0, "not refused when full");
            end
            push(16'(16'h1111 * (i + 1)), 16'(16'hEEEE - i));
        end
        @(negedge sys_clk_i) valid = 0;
        repeat (1400) @(posedge link_clk);
        check(n_irq - k, 1, "refill irq count");
        check(exp_q.size(), 0, "burst left");
        @(posedge chan_clk);
        @(negedge link_clk);
        acc = 0;
        hi = 0;
        tg = 0;
        m_prev = mclk;
        repeat (128) @(negedge link_clk) begin
            acc += (sdo !== 1'b0);
            hi += (chan_clk === 1'b1);
            tg += (mclk !== m_prev);
            m_prev = mclk;
        end
        check({acc[7:0], hi[7:0], tg[7:0]}, {8'h00, 8'h40, 8'h80}, "idle frame");
        @(posedge chan_clk);
        push(16'h1234, 16'h4321);
        push(16'h5678, 16'h8765);
        @(negedge sys_clk_i) valid = 0;
        sys_rst_i = 1;
        repeat (5) @(posedge link_clk);
        @(negedge sys_clk_i);
        check({ready, irq, chan_clk, sdo}, 4'h0, "mid-run reset");
        exp_q.delete();
        sys_rst_i = 0;
        push(16'h0F0F, 16'hF0F0);
        @(negedge sys_clk_i) valid = 0;
        repeat (400) @(posedge link_clk);
        check(exp_q.size(), 0, "after reset");
        conclude;
    end
endmodule // sdp_top_tb_top
